// File: design/sar_adc_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================================
// Summary of operation
// - ten-bit successive approximation into result pair
// - channel field drives the shared sample-hold
// - independent positive and negative reference selects
// - clock select: div2, div8, div32, rc
// - full conversion takes exactly eleven bit periods
// - divider clocks follow system clock, rc not
// - completion sets flag; enable bit gates only the wake and the vector
// - flag set on every completion regardless
// - enabled completion in sleep wakes the core
// - result left or right justified by format
// - runs only when on; go starts conversion
// - completion clears go, sets flag, updates result
// - early go clear aborts, two-period holdoff
// - format bit seven, one means right justified
// - rc clock delays start by one instruction
module sar_adc_sequencer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // analog side
  input wire logic comp_in,
  input wire logic rc_osc_in,
  output sar_pkg::afe_ctrl_t afe_o,
  output logic [13:0] analog_pin_en,
  // core side
  input wire logic sleep_mode,
  output sar_pkg::core_evt_t core_evt_o
);
  import sar_pkg::*;

  // ================================================================
  // helper functions
  // true for every offset that holds a register
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_CTRL0) || (a == OFS_CTRL1) || (a == OFS_RES_HIGH) ||
                (a == OFS_RES_LOW) || (a == OFS_FLAG) || (a == OFS_ENABLE) ||
                (a == OFS_PIN_LOW) || (a == OFS_PIN_HIGH) || (a == OFS_CORE);
  endfunction : is_mapped

  // places the result in the high or low byte per format
  function automatic logic [7:0] fmt_result(input logic [9:0] r, input logic right,
                                            input logic hi);
    if (right) begin
      fmt_result = hi ? {6'h00, r[9:8]} : r[7:0];
    end else begin
      fmt_result = hi ? r[9:2] : {r[1:0], 6'h00};
    end
  endfunction : fmt_result

  // ================================================================
  // state declarations
  logic aw_got_r, aw_got_nxt; // write address held
  logic [7:0] awaddr_r, awaddr_nxt;
  logic w_got_r, w_got_nxt; // write data held
  logic [7:0] wbyte_r, wbyte_nxt; // lane zero of write data
  logic wlane_r, wlane_nxt; // lane zero strobe
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic wr_en; // write commits this cycle
  logic rd_en; // read taken this cycle
  // control and status
  logic on_r, on_nxt;
  logic go_r, go_nxt;
  logic [3:0] chs_r, chs_nxt;
  logic [1:0] clk_r, clk_nxt;
  logic just_r, just_nxt;
  logic vpos_r, vpos_nxt;
  logic vneg_r, vneg_nxt;
  logic flag_r, flag_nxt;
  logic ena_r, ena_nxt;
  logic gie_r, gie_nxt;
  logic [7:0] pin_lo_r, pin_lo_nxt;
  logic [5:0] pin_hi_r, pin_hi_nxt;
  logic [9:0] res_r, res_nxt;
  // sequencer
  seq_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt; // bit periods in conv or hold
  logic [2:0] wait_r, wait_nxt; // instruction delay count
  logic [9:0] sar_r, sar_nxt; // trial code
  logic [4:0] div_r, div_nxt; // free-running divider
  logic [4:0] div_last; // last divider count for the select
  logic tick; // one bit period has elapsed
  logic start, abort, done;
  logic [3:0] idx; // bit being decided
  // synchronisers
  logic comp_s1_r; // comparator answer, sampled once
  logic rc_s1_r, rc_s2_r, rc_s3_r;
  // outputs
  afe_ctrl_t afe_r, afe_nxt;
  core_evt_t evt_r, evt_nxt;
  logic [13:0] pins_r;

  // ================================================================
  // bus slave
  // latch address and data separately, answer once both are in
  always_comb begin
    aw_got_nxt = aw_got_r;
    awaddr_nxt = awaddr_r;
    w_got_nxt = w_got_r;
    wbyte_nxt = wbyte_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    wr_en = aw_got_r && w_got_r && !bvalid_r;
    rd_en = s_axi_arvalid && arready_r;
    // address channel
    if (s_axi_awvalid && awready_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    // data channel
    if (s_axi_wvalid && wready_r) begin
      w_got_nxt = 1'b1;
      wbyte_nxt = s_axi_wdata[7:0];
      wlane_nxt = s_axi_wstrb[0];
    end
    // commit and respond
    if (wr_en) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // read data, sampled at the address handshake
    if (rd_en) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_nxt = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFS_CTRL0: rdata_nxt[7:0] = {clk_r, chs_r, go_r, on_r};
        OFS_CTRL1: rdata_nxt[7:0] = {just_r, 1'b0, vneg_r, vpos_r, 4'h0};
        OFS_RES_HIGH: rdata_nxt[7:0] = fmt_result(res_r, just_r, 1'b1);
        OFS_RES_LOW: rdata_nxt[7:0] = fmt_result(res_r, just_r, 1'b0);
        OFS_FLAG: rdata_nxt[DONE_FLAG_BIT] = flag_r;
        OFS_ENABLE: rdata_nxt[DONE_ENABLE_BIT] = ena_r;
        OFS_PIN_LOW: rdata_nxt[7:0] = pin_lo_r;
        OFS_PIN_HIGH: rdata_nxt[5:0] = pin_hi_r;
        OFS_CORE: rdata_nxt[CORE_GIE_BIT] = gie_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    // one write and one read at a time
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt = !w_got_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  // registers of the bus slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      w_got_r <= 1'b0;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end else begin
      aw_got_r <= aw_got_nxt;
      awaddr_r <= awaddr_nxt;
      w_got_r <= w_got_nxt;
      wbyte_r <= wbyte_nxt;
      wlane_r <= wlane_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ================================================================
  // synchronisers and bit-period enable
  // the rc edge passes two flops; the comparator answers our own registered
  // trial and settles within a cycle, so one sampling flop keeps divide by two current
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_s1_r <= 1'b0;
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
    end else begin
      comp_s1_r <= comp_in;
      rc_s1_r <= rc_osc_in;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
    end
  end

  // divider runs free; the rc edge does not depend on aclk rate
  always_comb begin
    unique case (clk_r)
      CLK_DIV2: div_last = 5'(DIV2_CLKS - 6'h01);
      CLK_DIV8: div_last = 5'(DIV8_CLKS - 6'h01);
      CLK_DIV32: div_last = 5'(DIV32_CLKS - 6'h01);
      CLK_RC: div_last = 5'(DIV32_CLKS - 6'h01);
    endcase
    div_nxt = (div_r >= div_last) ? 5'h00 : 5'(div_r + 5'h01);
    tick = (clk_r == CLK_RC) ? (rc_s2_r && !rc_s3_r) : (div_r >= div_last);
  end

  // ================================================================
  // control registers and conversion sequencer
  always_comb begin
    on_nxt = on_r;
    go_nxt = go_r;
    chs_nxt = chs_r;
    clk_nxt = clk_r;
    just_nxt = just_r;
    vpos_nxt = vpos_r;
    vneg_nxt = vneg_r;
    flag_nxt = flag_r;
    ena_nxt = ena_r;
    gie_nxt = gie_r;
    pin_lo_nxt = pin_lo_r;
    pin_hi_nxt = pin_hi_r;
    res_nxt = res_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wait_nxt = wait_r;
    sar_nxt = sar_r;
    start = 1'b0;
    abort = 1'b0;
    done = 1'b0;
    idx = 4'(RES_BITS - cnt_r);
    // software writes, lane zero only
    if (wr_en && wlane_r) begin
      unique case (awaddr_r)
        OFS_CTRL0: begin
          clk_nxt = wbyte_r[CTRL0_CLK_LSB +: 2];
          chs_nxt = wbyte_r[CTRL0_CHS_LSB +: 4];
          on_nxt = wbyte_r[CTRL0_ON_BIT];
          if (!wbyte_r[CTRL0_ON_BIT]) begin
            go_nxt = 1'b0;
          end else if (wbyte_r[CTRL0_GO_BIT] && !go_r && on_r) begin
            start = 1'b1;
          end else if (!wbyte_r[CTRL0_GO_BIT] && go_r) begin
            abort = 1'b1;
          end
        end
        OFS_CTRL1: begin
          just_nxt = wbyte_r[CTRL1_JUST_BIT];
          vneg_nxt = wbyte_r[CTRL1_VNEG_BIT];
          vpos_nxt = wbyte_r[CTRL1_VPOS_BIT];
        end
        OFS_FLAG: flag_nxt = wbyte_r[DONE_FLAG_BIT];
        OFS_ENABLE: ena_nxt = wbyte_r[DONE_ENABLE_BIT];
        OFS_PIN_LOW: pin_lo_nxt = wbyte_r;
        OFS_PIN_HIGH: pin_hi_nxt = wbyte_r[5:0];
        OFS_CORE: gie_nxt = wbyte_r[CORE_GIE_BIT];
        default: ;
      endcase
    end
    // sleep on a divided clock kills the conversion
    if (sleep_mode && clk_r != CLK_RC && go_r) begin
      abort = 1'b1;
    end
    // sequencer
    unique case (st_r)
      ST_IDLE: begin
        if (start) begin
          go_nxt = 1'b1;
          cnt_nxt = 4'h0;
          wait_nxt = 3'h0;
          // a clock select written together with go already counts
          st_nxt = (clk_nxt == CLK_RC) ? ST_WAIT : ST_CONV;
        end
      end
      ST_WAIT: begin
        wait_nxt = 3'(wait_r + 3'h1);
        if (wait_r == 3'(INSTR_CLKS - 3'h1)) begin
          st_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (tick && cnt_r == 4'h0) begin
          sar_nxt = 10'h200;
          cnt_nxt = 4'h1;
        end else if (tick) begin
          sar_nxt[idx] = comp_s1_r;
          if (idx != 4'h0) begin
            sar_nxt[idx - 4'h1] = 1'b1;
          end
          cnt_nxt = 4'(cnt_r + 4'h1);
          if (cnt_r == 4'(CONV_TADS - 4'h1)) begin
            done = 1'b1;
          end
        end
      end
      ST_HOLD: begin
        if (tick) begin
          cnt_nxt = 4'(cnt_r + 4'h1);
          if (cnt_r == 4'(ABORT_TADS - 4'h1)) begin
            st_nxt = ST_IDLE;
          end
        end
      end
    endcase
    // completion and abort
    if (done) begin
      go_nxt = 1'b0;
      res_nxt = sar_nxt;
      st_nxt = ST_IDLE;
    end
    if (abort && st_r != ST_IDLE) begin
      go_nxt = 1'b0;
      cnt_nxt = 4'h0;
      st_nxt = ST_HOLD;
    end
    if (!on_nxt) begin
      go_nxt = 1'b0;
      st_nxt = ST_IDLE;
    end
    // hardware set wins over a software clear
    if (done) begin
      flag_nxt = 1'b1;
    end
    // front end controls and core events
    afe_nxt.chan = chs_r;
    afe_nxt.vpos_ext = vpos_r;
    afe_nxt.vneg_ext = vneg_r;
    afe_nxt.track = (st_nxt == ST_IDLE) || (st_nxt == ST_HOLD) || (st_nxt == ST_WAIT);
    afe_nxt.trial = sar_nxt;
    evt_nxt.wake = done && sleep_mode && ena_r;
    evt_nxt.vector = done && sleep_mode && ena_r && gie_r;
  end

  // registers of control and sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_r <= CTRL0_RST[CTRL0_ON_BIT];
      go_r <= CTRL0_RST[CTRL0_GO_BIT];
      chs_r <= CTRL0_RST[CTRL0_CHS_LSB +: 4];
      clk_r <= CTRL0_RST[CTRL0_CLK_LSB +: 2];
      just_r <= CTRL1_RST[CTRL1_JUST_BIT];
      vpos_r <= CTRL1_RST[CTRL1_VPOS_BIT];
      vneg_r <= CTRL1_RST[CTRL1_VNEG_BIT];
      flag_r <= 1'b0;
      ena_r <= 1'b0;
      gie_r <= 1'b0;
      pin_lo_r <= PIN_LOW_RST;
      pin_hi_r <= PIN_HIGH_RST;
      res_r <= RESULT_RST;
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      wait_r <= 3'h0;
      sar_r <= 10'h000;
      div_r <= 5'h00;
      afe_r <= '0;
      evt_r <= '0;
      pins_r <= {PIN_HIGH_RST, PIN_LOW_RST};
    end else begin
      on_r <= on_nxt;
      go_r <= go_nxt;
      chs_r <= chs_nxt;
      clk_r <= clk_nxt;
      just_r <= just_nxt;
      vpos_r <= vpos_nxt;
      vneg_r <= vneg_nxt;
      flag_r <= flag_nxt;
      ena_r <= ena_nxt;
      gie_r <= gie_nxt;
      pin_lo_r <= pin_lo_nxt;
      pin_hi_r <= pin_hi_nxt;
      res_r <= res_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wait_r <= wait_nxt;
      sar_r <= sar_nxt;
      div_r <= div_nxt;
      afe_r <= afe_nxt;
      evt_r <= evt_nxt;
      pins_r <= {pin_hi_nxt, pin_lo_nxt};
    end
  end

  // ports straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign afe_o = afe_r;
  assign core_evt_o = evt_r;
  assign analog_pin_en = pins_r;

  // ================================================================
  // checks
  logic [3:0] conv_ticks_r; // ticks seen in the current conversion
  always_ff @(posedge aclk) begin
    if (!aresetn || st_r != ST_CONV) begin
      conv_ticks_r <= 4'h0;
    end else if (tick) begin
      conv_ticks_r <= 4'(conv_ticks_r + 4'h1);
    end
  end

  conv_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
    done |-> conv_ticks_r == 4'(CONV_TADS - 4'h1))
    else $error("conversion did not span eleven bit periods");
  done_update_a: assert property (@(posedge aclk) disable iff (!aresetn)
    done |=> !go_r && flag_r && res_r == $past(sar_nxt) && st_r == ST_IDLE)
    else $error("completion effects missing");
  abort_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ST_HOLD) |-> $stable(res_r) && !go_r)
    else $error("result changed during abort holdoff");
  holdoff_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ST_HOLD && tick && cnt_r == 4'h1 && on_r) |=> st_r == ST_IDLE)
    else $error("holdoff not ended after two bit periods");
  msb_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ST_CONV && tick && cnt_r == 4'h0 && on_nxt && !abort) |=> sar_r == 10'h200)
    else $error("first trial is not the msb");
  div2_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_r == CLK_DIV2 && tick) ##1 (clk_r == CLK_DIV2) ##1 (clk_r == CLK_DIV2) |->
      tick && !$past(tick))
    else $error("divide by two enable out of step");
  rc_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ST_IDLE && start && clk_nxt == CLK_RC && on_nxt) |=> st_r == ST_WAIT [*4])
    else $error("rc start delay wrong length");
  flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_r && !(wr_en && wlane_r && awaddr_r == OFS_FLAG)) |=> flag_r)
    else $error("completion flag cleared by hardware");
  wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (done && sleep_mode && ena_r) |=> core_evt_o.wake && (core_evt_o.vector == $past(gie_r)))
    else $error("no wake on enabled completion in sleep");
  off_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !on_r |-> st_r == ST_IDLE && !go_r)
    else $error("sequencer active while converter off");
  chan_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 afe_o.chan == $past(chs_r))
    else $error("channel output does not follow field");

endmodule : sar_adc_sequencer
`default_nettype wire

// File: design/sar_pkg.sv
// ==================================================================
// shared constants and types of the converter sequencer
package sar_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_RES_HIGH = 8'h08;
  localparam logic [7:0] OFS_RES_LOW = 8'h0c;
  localparam logic [7:0] OFS_FLAG = 8'h10;
  localparam logic [7:0] OFS_ENABLE = 8'h14;
  localparam logic [7:0] OFS_PIN_LOW = 8'h18;
  localparam logic [7:0] OFS_PIN_HIGH = 8'h1c;
  localparam logic [7:0] OFS_CORE = 8'h20;
  // field positions
  localparam int unsigned CTRL0_ON_BIT = 0;
  localparam int unsigned CTRL0_GO_BIT = 1;
  localparam int unsigned CTRL0_CHS_LSB = 2;
  localparam int unsigned CTRL0_CLK_LSB = 6;
  localparam int unsigned CTRL1_JUST_BIT = 7;
  localparam int unsigned CTRL1_VNEG_BIT = 5;
  localparam int unsigned CTRL1_VPOS_BIT = 4;
  localparam int unsigned DONE_FLAG_BIT = 6;
  localparam int unsigned DONE_ENABLE_BIT = 6;
  localparam int unsigned CORE_GIE_BIT = 0;
  // reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] PIN_LOW_RST = 8'hff;
  localparam logic [5:0] PIN_HIGH_RST = 6'h3f;
  localparam logic [9:0] RESULT_RST = 10'h000;
  // conversion clock select codes
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV8 = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_RC = 2'h3;
  // timing counts
  localparam logic [5:0] DIV2_CLKS = 6'h02;
  localparam logic [5:0] DIV8_CLKS = 6'h08;
  localparam logic [5:0] DIV32_CLKS = 6'h20;
  localparam logic [3:0] RES_BITS = 4'ha;
  localparam logic [3:0] CONV_TADS = 4'hb;
  localparam logic [3:0] ABORT_TADS = 4'h2;
  localparam logic [2:0] INSTR_CLKS = 3'h4;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10,
    ST_HOLD = 2'b11
  } seq_state_t;
  // controls toward the analog front end
  typedef struct packed {
    logic [3:0] chan;
    logic vpos_ext;
    logic vneg_ext;
    logic track;
    logic [9:0] trial;
  } afe_ctrl_t;
  // event pulses toward the core
  typedef struct packed {
    logic wake;
    logic vector;
  } core_evt_t;
endpackage : sar_pkg

// File: verif/afe_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================================
// comparator and rc oscillator of the analog front end
module afe_model #(
  parameter realtime RC_HALF = 153.7 // rc half period, unrelated to aclk
) (
  // controls from the sequencer
  input wire sar_pkg::afe_ctrl_t afe_i,
  input wire logic [9:0] vin_code,
  // answers to the sequencer
  output logic comp_o,
  output logic rc_o
);
  import sar_pkg::*;
  // comparator is only meaningful while the hold is disconnected
  initial comp_o = 1'b0;
  always @(afe_i or vin_code) begin
    if (!afe_i.track) begin
      comp_o = (vin_code >= afe_i.trial);
    end else begin
      comp_o = ~comp_o; // no stale answer while tracking
    end
  end
  // the dedicated oscillator runs free of the system clock
  initial begin
    rc_o = 1'b0;
    forever #(RC_HALF) rc_o = ~rc_o;
  end
endmodule : afe_model
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================================
// register level tests of the converter sequencer
module tb;
  import sar_pkg::*;
  // bus and core drives
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic sleep_mode = 1'b0;
  logic [9:0] vin = 10'h000;
  // design answers
  logic awready, wready, bvalid, arready, rvalid, comp, rc;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  afe_ctrl_t afe;
  core_evt_t evt;
  logic [13:0] pin_en;
  // bookkeeping
  int fails = 0;
  int samples_checked = 0;
  logic [31:0] wakes = 32'h0, vecs = 32'h0, lows = 32'h0;
  logic [1:0] rresp_seen;
  // ==================================================================
  // instances
  sar_adc_sequencer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .comp_in(comp),
    .rc_osc_in(rc), .afe_o(afe), .analog_pin_en(pin_en), .sleep_mode(sleep_mode),
    .core_evt_o(evt));
  afe_model front (.afe_i(afe), .vin_code(vin), .comp_o(comp), .rc_o(rc));
  // ==================================================================
  // clock, event and period counting
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (evt.wake === 1'b1) wakes <= wakes + 32'h1;
    if (evt.vector === 1'b1) vecs <= vecs + 32'h1;
    if (afe.track === 1'b0) lows <= lows + 32'h1;
  end
  // ==================================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // the loop test reads the levels that stood at this edge
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        rresp_seen = rresp;
        rready <= 1'b0;
      end
    end while (arvalid || rready);
  endtask : rd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask : rchk
  // start a conversion and poll the go bit, bounded
  task automatic conv(input logic [7:0] c, input logic [9:0] v);
    logic [31:0] d;
    int n;
    vin <= v;
    lows = 32'h0;
    wr(OFS_CTRL0, c);
    repeat (20) @(posedge aclk);
    wr(OFS_CTRL0, c | 8'h02);
    n = 0;
    d = 32'h2;
    while (d[1] !== 1'b0 && n < 400) begin
      rd(OFS_CTRL0, d);
      n++;
    end
  endtask : conv
  task automatic summarize;
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // ==================================================================
  // watchdog
  initial begin
    #(25.0 * 60000);
    fails++;
    summarize();
  end
  // ==================================================================
  // test sequence
  initial begin
    logic [31:0] d, eh, el;
    logic [9:0] codes [5];
    int dv [3];
    logic [1:0] cs;
    codes = '{10'h2b5, 10'h0ff, 10'h301, 10'h155, 10'h2ca};
    dv = '{2, 8, 32};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("pin_en_rst", 32'h3fff, {18'h0, pin_en});
    rchk("pin_low_rst", OFS_PIN_LOW, 32'hff);
    rchk("pin_high_rst", OFS_PIN_HIGH, 32'h3f);
    rchk("ctrl0_rst", OFS_CTRL0, 32'h0);
    rd(8'h40, d);
    chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, rresp_seen});
    wr(OFS_PIN_LOW, 8'h5a);
    chk("pin_en", 32'h3f5a, {18'h0, pin_en});
    wr(OFS_CTRL0, 8'h03);
    rchk("go_with_on", OFS_CTRL0, 32'h01);
    wr(OFS_CTRL1, 8'hb0);
    chk("refs_both", 32'h3, {30'h0, afe.vpos_ext, afe.vneg_ext});
    for (int k = 0; k < 5; k++) begin
      cs = (k > 3) ? CLK_RC : k[1:0];
      wr(OFS_CTRL1, k[0] ? 8'h10 : 8'h90);
      wr(OFS_ENABLE, (k >= 2) ? 8'h40 : 8'h00);
      wr(OFS_CORE, {7'h0, k == 4});
      wr(OFS_FLAG, 8'h00);
      sleep_mode <= (k >= 3);
      wakes = 32'h0;
      vecs = 32'h0;
      conv({cs, 4'h5, 2'b01}, codes[k]);
      chk("chan", 32'h5, {28'h0, afe.chan});
      chk("ref_pos_only", 32'h2, {30'h0, afe.vpos_ext, afe.vneg_ext});
      rchk("flag", OFS_FLAG, 32'h40);
      eh = k[0] ? {24'h0, codes[k][9:2]} : {30'h0, codes[k][9:8]};
      el = k[0] ? {24'h0, codes[k][1:0], 6'h0} : {24'h0, codes[k][7:0]};
      rchk("res_high", OFS_RES_HIGH, eh);
      rchk("res_low", OFS_RES_LOW, el);
      if (k < 3) chk("span", 32'h1, {31'h0, lows >= 10 * dv[k] && lows <= 11 * dv[k] + 1});
      chk("wake", {31'h0, k >= 3}, wakes);
      chk("vector", {31'h0, k == 4}, vecs);
    end
    sleep_mode <= 1'b0;
    vin <= 10'h3aa;
    wr(OFS_CTRL0, 8'h81);
    repeat (20) @(posedge aclk);
    wr(OFS_CTRL0, 8'h83);
    repeat (100) @(posedge aclk);
    wr(OFS_CTRL0, 8'h81);
    rchk("abort_go", OFS_CTRL0, 32'h81);
    chk("abort_track", 32'h1, {31'h0, afe.track});
    rchk("abort_keep", OFS_RES_LOW, {24'h0, codes[4][7:0]});
    repeat (80) @(posedge aclk);
    conv(8'h01, 10'h123);
    rchk("restart", OFS_RES_LOW, 32'h23);
    wr(OFS_FLAG, 8'h00);
    rchk("flag_clear", OFS_FLAG, 32'h0);
    summarize();
  end
endmodule : tb
`default_nettype wire
